// *** hw/spp_setpoint_provider.sv ***
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
module spp_setpoint_provider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [15:0] first_far_input,
    input wire logic [15:0] second_far_input,
    output logic [15:0] active_target,
    output logic slew_complete,
    output logic [15:0] active_target_scaled_units
);
    spp_pkg::spp_state_t st;
    spp_pkg::spp_state_t next_st;
    logic setup;
    logic wr;
    logic mapped;
    logic [31:0] rd_word;
    logic [31:0] merged;
    logic [15:0] remote_sel;
    logic [15:0] raw;
    logic [15:0] pct_q;
    logic [15:0] pct_sel;
    logic [15:0] target;
    logic [15:0] eng_q;
    logic [15:0] diff;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;

    // remote path stays live whatever the edit permit says
    assign remote_sel = st.ctrl.remote_choice ? second_far_input : first_far_input;
    assign raw = st.ctrl.source_remote ? remote_sel : st.local_value;

    // engineering entry to hundredths of a percent of full scale
    spp_muldiv u_eng2pct (
        .pclk(pclk),
        .presetn(presetn),
        .a(raw),
        .b(spp_pkg::SPP_PCT_FULL),
        .c(st.full_scale),
        .q(pct_q)
    );

    assign pct_sel = st.ctrl.unit_eng ? pct_q : raw;

    spp_muldiv u_limit (
        .pclk(pclk),
        .presetn(presetn),
        .a(pct_sel),
        .b({8'h00, st.limit}),
        .c(spp_pkg::SPP_LIMIT_DIV),
        .q(target)
    );

    // indication only, never fed back into the target path
    spp_muldiv u_pct2eng (
        .pclk(pclk),
        .presetn(presetn),
        .a(st.active),
        .b(st.full_scale),
        .c(spp_pkg::SPP_PCT_FULL),
        .q(eng_q)
    );

    always_comb begin
        mapped = 1'b1;
        rd_word = 32'h00000000;
        case (paddr)
            spp_pkg::SPP_OFF_CTRL: rd_word = {26'h0000000, st.ctrl};
            spp_pkg::SPP_OFF_LOCAL: rd_word = {16'h0000, st.local_value};
            spp_pkg::SPP_OFF_LIMIT: rd_word = {24'h000000, st.limit};
            spp_pkg::SPP_OFF_SLEW: rd_word = {16'h0000, st.slew_rate};
            spp_pkg::SPP_OFF_FSCALE: rd_word = {16'h0000, st.full_scale};
            spp_pkg::SPP_OFF_STATUS: rd_word = {31'h00000000, st.complete};
            spp_pkg::SPP_OFF_ACTIVE: rd_word = {16'h0000, st.active};
            spp_pkg::SPP_OFF_ENG: rd_word = {16'h0000, st.eng_out};
            default: mapped = 1'b0;
        endcase
    end

    assign merged = wmerge(rd_word, pwdata, pstrb);
    assign diff = (st.active > target) ? st.active - target : target - st.active;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.tick_cnt == spp_pkg::SPP_TICK_LAST) begin
            next_st.tick_cnt = 7'h00;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 7'h01;
        end
        if (wr) begin
            case (paddr)
                spp_pkg::SPP_OFF_CTRL: next_st.ctrl = spp_pkg::spp_ctrl_t'(merged[5:0]);
                spp_pkg::SPP_OFF_LOCAL: begin
                    if (st.ctrl.edit_permit) begin
                        next_st.local_value = merged[15:0];
                    end
                end
                spp_pkg::SPP_OFF_LIMIT: next_st.limit = merged[7:0];
                spp_pkg::SPP_OFF_SLEW: next_st.slew_rate = merged[15:0];
                spp_pkg::SPP_OFF_FSCALE: next_st.full_scale = merged[15:0];
                default: next_st.ctrl = st.ctrl;
            endcase
        end
        // follow wins over a software write in the same cycle
        if (st.ctrl.follow) begin
            next_st.local_value = remote_sel;
        end
        if (st.ctrl.bypass) begin
            next_st.active = target;
        end else if (st.tick) begin
            if (st.slew_rate == 16'h0000 || diff <= st.slew_rate) begin
                next_st.active = target;
            end else if (st.active < target) begin
                next_st.active = st.active + st.slew_rate;
            end else begin
                next_st.active = st.active - st.slew_rate;
            end
        end
        next_st.complete = st.ctrl.bypass | (next_st.active == target);
        next_st.eng_out = st.ctrl.unit_eng ? eng_q : 16'h0000;
        if (setup) begin
            next_st.pslverr = ~mapped;
            next_st.prdata = rd_word;
            if (!st.ctrl.unit_eng && (paddr == spp_pkg::SPP_OFF_FSCALE || paddr == spp_pkg::SPP_OFF_ENG)) begin
                next_st.prdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.ctrl <= spp_pkg::spp_ctrl_t'(spp_pkg::SPP_CTRL_RST);
            st.local_value <= spp_pkg::SPP_LOCAL_RST;
            st.limit <= spp_pkg::SPP_LIMIT_RST;
            st.slew_rate <= spp_pkg::SPP_SLEW_RST;
            st.full_scale <= spp_pkg::SPP_FSCALE_RST;
            st.complete <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign pready = 1'b1;
    assign prdata = st.prdata;
    assign pslverr = psel & penable & st.pslverr;
    assign active_target = st.active;
    assign slew_complete = st.complete;
    assign active_target_scaled_units = st.eng_out;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_local_write;
        wr && paddr == spp_pkg::SPP_OFF_LOCAL && pstrb == 4'hF;
    endsequence

    sequence s_locked;
        !st.ctrl.edit_permit && !st.ctrl.follow;
    endsequence

    a_local_pick: assert property (!st.ctrl.source_remote |-> raw == st.local_value)
        else $error("local source not used");
    a_remote_pick: assert property (st.ctrl.source_remote && !st.ctrl.remote_choice |-> raw == first_far_input)
        else $error("first remote input not used");
    a_second_pick: assert property (st.ctrl.source_remote && st.ctrl.remote_choice
        |-> raw == second_far_input)
        else $error("second remote input not used");
    a_limit_unity: assert property (st.limit == spp_pkg::SPP_LIMIT_RST |=> target == $past(pct_sel))
        else $error("unity limit altered setpoint");
    a_bypass_copy: assert property (st.ctrl.bypass |=> st.active == $past(target) && st.complete)
        else $error("bypass did not copy target");
    a_hold_between: assert property (!st.ctrl.bypass && !st.tick |=> st.active == $past(st.active))
        else $error("working setpoint moved without tick");
    a_step_bound: assert property (st.tick && !st.ctrl.bypass && st.slew_rate != 16'h0000 && st.active < target
        |=> (st.active - $past(st.active)) <= $past(st.slew_rate) && st.active <= $past(target))
        else $error("slew step too large or overshoot");
    a_done_rise: assert property (st.complete && !$past(st.complete) |-> st.active == $past(target))
        else $error("completion raised before target");
    a_done_track: assert property (!st.ctrl.bypass |=> st.complete == (st.active == $past(target)))
        else $error("completion flag does not match slew state");
    a_step_down: assert property (st.tick && !st.ctrl.bypass && st.slew_rate != 16'h0000 && st.active > target
        |=> ($past(st.active) - st.active) <= $past(st.slew_rate) && st.active >= $past(target))
        else $error("falling slew step too large or undershoot");
    a_zero_jump: assert property (st.tick && !st.ctrl.bypass && st.slew_rate == 16'h0000
        |=> st.active == $past(target))
        else $error("zero slew rate did not jump to target");
    a_follow_copy: assert property (st.ctrl.follow |=> st.local_value == $past(remote_sel))
        else $error("local value not following remote");
    a_edit_lock: assert property (s_local_write ##0 s_locked |=> st.local_value == $past(st.local_value))
        else $error("locked local value was written");
    a_eng_hidden: assert property (!st.ctrl.unit_eng |=> active_target_scaled_units == 16'h0000)
        else $error("engineering value shown in percent mode");
endmodule // spp_setpoint_provider

// *** hw/spp_pkg.sv ***
// Behaviour
// - source select picks local or remote
// - remote choice picks first or second input
// - local selection uses entered local value
// - target scaled by limit over one hundred
// - output is target or slewed target
// - slew limited, completion false until reached
// - bypass copies target, completion held true
// - follow keeps local equal to remote
// - local edits allowed only when permitted
// - remote inputs adjust the setpoint whatever the edit permit
// - percent or engineering units; range hidden otherwise
// - full scale converts engineering to percent
package spp_pkg;
    localparam int SPP_DW = 16;
    localparam int SPP_AW = 8;

    localparam logic [7:0] SPP_OFF_CTRL = 8'h00;
    localparam logic [7:0] SPP_OFF_LOCAL = 8'h04;
    localparam logic [7:0] SPP_OFF_LIMIT = 8'h08;
    localparam logic [7:0] SPP_OFF_SLEW = 8'h0C;
    localparam logic [7:0] SPP_OFF_FSCALE = 8'h10;
    localparam logic [7:0] SPP_OFF_STATUS = 8'h14;
    localparam logic [7:0] SPP_OFF_ACTIVE = 8'h18;
    localparam logic [7:0] SPP_OFF_ENG = 8'h1C;

    localparam logic [5:0] SPP_CTRL_RST = 6'h00;
    localparam logic [15:0] SPP_LOCAL_RST = 16'h0000;
    localparam logic [7:0] SPP_LIMIT_RST = 8'h64;
    localparam logic [15:0] SPP_LIMIT_DIV = 16'h0064;
    localparam logic [15:0] SPP_SLEW_RST = 16'h0064;
    localparam logic [15:0] SPP_FSCALE_RST = 16'h2710;
    // percent carried in hundredths: 10000 is 100.00 %
    localparam logic [15:0] SPP_PCT_FULL = 16'h2710;

    localparam int SPP_CLK_NS = 10;
    localparam int SPP_TICK_NS = 1000;
    localparam int SPP_TICK_CYC = (SPP_TICK_NS + SPP_CLK_NS - 1) / SPP_CLK_NS;
    localparam logic [6:0] SPP_TICK_LAST = 7'(SPP_TICK_CYC - 1);

    typedef struct packed {
        logic unit_eng;
        logic edit_permit;
        logic follow;
        logic bypass;
        logic remote_choice;
        logic source_remote;
    } spp_ctrl_t;

    typedef struct packed {
        spp_ctrl_t ctrl;
        logic [15:0] local_value;
        logic [7:0] limit;
        logic [15:0] slew_rate;
        logic [15:0] full_scale;
        logic [15:0] active;
        logic complete;
        logic [15:0] eng_out;
        logic [6:0] tick_cnt;
        logic tick;
        logic [31:0] prdata;
        logic pslverr;
    } spp_state_t;

    typedef struct packed {
        logic [15:0] q;
    } spp_md_t;
endpackage

// *** hw/spp_muldiv.sv ***
`timescale 1ns/1ps
module spp_muldiv (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] a,
    input wire logic [15:0] b,
    input wire logic [15:0] c,
    output logic [15:0] q
);
    spp_pkg::spp_md_t st;
    spp_pkg::spp_md_t next_st;
    logic [31:0] prod;
    logic [31:0] quot;

    // saturates rather than wrapping; zero divisor reads as full
    always_comb begin
        prod = 32'(a) * 32'(b);
        quot = (c == 16'h0000) ? 32'hFFFFFFFF : prod / 32'(c);
        next_st.q = (quot > 32'h0000FFFF) ? 16'hFFFF : quot[15:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;
endmodule // spp_muldiv

// *** sim/spp_setpoint_provider_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t got %h expected %h", $time, g, e); end end
module spp_setpoint_provider_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mon = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, rd_data;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, slew_complete, rd_err;
    logic [31:0] prdata;
    logic [15:0] first_far_input = 16'h0300, second_far_input = 16'h0600, active_target, scaled, prev;
    int error_cnt = 0, total_checks = 0;
    spp_setpoint_provider DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .first_far_input(first_far_input),
        .second_far_input(second_far_input), .active_target(active_target),
        .slew_complete(slew_complete), .active_target_scaled_units(scaled));
    initial forever #5 pclk = ~pclk;
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // master holds the request until pready is seen high at an edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h00000000);
        `CHK(rd_data, e)
    endtask
    // step size watch: the target only rises during the slew scenario
    always @(posedge pclk) begin
        if (mon) `CHK(((active_target - prev) <= 16'h0180), 1'b1)
        prev = active_target;
    end
    initial begin
        #200000;
        error_cnt++;
        complete_run;
    end
    initial begin
        wt(5);
        presetn <= 1'b1;
        rc(spp_pkg::SPP_OFF_CTRL, 32'h00000000);
        rc(spp_pkg::SPP_OFF_LOCAL, 32'h00000000);
        rc(spp_pkg::SPP_OFF_LIMIT, 32'h00000064);
        rc(spp_pkg::SPP_OFF_SLEW, 32'h00000064);
        rc(spp_pkg::SPP_OFF_FSCALE, 32'h00000000);
        rc(spp_pkg::SPP_OFF_STATUS, 32'h00000001);
        rc(spp_pkg::SPP_OFF_ENG, 32'h00000000);
        apb(8'h20, 1'b0, 32'h00000000);
        `CHK(rd_err, 1'b1)
        `CHK(rd_data, 32'h00000000)
        wr(spp_pkg::SPP_OFF_CTRL, 32'h00000014);
        wr(spp_pkg::SPP_OFF_LOCAL, 32'h00001000);
        wt(10);
        `CHK(active_target, 16'h1000)
        `CHK(slew_complete, 1'b1)
        wr(spp_pkg::SPP_OFF_LIMIT, 32'h00000032);
        wt(10);
        `CHK(active_target, 16'h0800)
        wr(spp_pkg::SPP_OFF_LIMIT, 32'h00000064);
        wr(spp_pkg::SPP_OFF_CTRL, 32'h00000005);
        wr(spp_pkg::SPP_OFF_LOCAL, 32'h00002000);
        rc(spp_pkg::SPP_OFF_LOCAL, 32'h00001000);
        wt(10);
        `CHK(active_target, 16'h0300)
        first_far_input <= 16'h0350;
        wt(10);
        `CHK(active_target, 16'h0350)
        wr(spp_pkg::SPP_OFF_CTRL, 32'h00000007);
        wt(10);
        `CHK(active_target, 16'h0600)
        first_far_input <= 16'h0600;
        pstrb <= 4'h2;
        wr(spp_pkg::SPP_OFF_SLEW, 32'h00000180);
        pstrb <= 4'hF;
        rc(spp_pkg::SPP_OFF_SLEW, 32'h00000164);
        wr(spp_pkg::SPP_OFF_SLEW, 32'h00000180);
        wr(spp_pkg::SPP_OFF_CTRL, 32'h00000001);
        wt(10);
        mon <= 1'b1;
        first_far_input <= 16'h0B00;
        wt(20);
        `CHK(slew_complete, 1'b0)
        `CHK((active_target < 16'h0B00), 1'b1)
        wt(500);
        `CHK(active_target, 16'h0B00)
        `CHK(slew_complete, 1'b1)
        mon <= 1'b0;
        first_far_input <= 16'h0800;
        wt(50);
        `CHK(slew_complete, 1'b0)
        `CHK((active_target > 16'h0800), 1'b1)
        wt(250);
        `CHK(active_target, 16'h0800)
        wr(spp_pkg::SPP_OFF_SLEW, 32'h00000000);
        first_far_input <= 16'h0B00;
        wt(110);
        `CHK(active_target, 16'h0B00)
        wr(spp_pkg::SPP_OFF_CTRL, 32'h00000009);
        wt(5);
        rc(spp_pkg::SPP_OFF_LOCAL, 32'h00000B00);
        wr(spp_pkg::SPP_OFF_CTRL, 32'h00000000);
        wt(5);
        `CHK(active_target, 16'h0B00)
        `CHK(slew_complete, 1'b1)
        wr(spp_pkg::SPP_OFF_CTRL, 32'h00000025);
        wr(spp_pkg::SPP_OFF_FSCALE, 32'h00001388);
        first_far_input <= 16'h09C4;
        wt(10);
        `CHK(active_target, 16'h1388)
        `CHK(scaled, 16'h09C4)
        rc(spp_pkg::SPP_OFF_FSCALE, 32'h00001388);
        rc(spp_pkg::SPP_OFF_ENG, 32'h000009C4);
        wr(spp_pkg::SPP_OFF_ACTIVE, 32'h0000FFFF);
        rc(spp_pkg::SPP_OFF_ACTIVE, 32'h00001388);
        wr(spp_pkg::SPP_OFF_CTRL, 32'h00000005);
        wt(10);
        `CHK(scaled, 16'h0000)
        complete_run;
    end
endmodule // spp_setpoint_provider_test
